// file: rtl/qsfe_pkg.sv
// Package for the queued serial frame engine: selector codes, reset codes,
// frame and timing constants shared by the engine and its bench.
// Assumes a 20 MHz system clock.
package qsfe_pkg;
	// System clock period in ns
	localparam int unsigned QSFE_CLK_NS = 50;
	// Phase transition selector codes
	localparam logic [2:0] QSFE_PT_SOF = 3'h2;
	localparam logic [2:0] QSFE_PT_RBF = 3'h4;
	localparam logic [2:0] QSFE_PT_EOF = 3'h5;
	localparam logic [2:0] QSFE_PT_SSDESEL = 3'h5;
	// Soft reset select code for bit counter and state machine
	localparam logic [1:0] QSFE_RST_BITSM = 2'h1;
	// Data width of a frame word
	localparam int unsigned QSFE_DW = 16;
	// Frame length field width
	localparam int unsigned QSFE_LW = 5;
	// Spike filter: input must be stable this many cycles plus two
	localparam logic [1:0] QSFE_SPIKE_CYC = 2'h2;
	// Baud quantum counter width
	localparam int unsigned QSFE_TQW = 8;
	// Period measure counter width
	localparam int unsigned QSFE_PW = 12;
	// Reset value of the bit counter
	localparam logic [QSFE_LW-1:0] QSFE_BIT_ZERO = 5'h00;
	// Fill pattern on transmit underflow
	localparam logic [QSFE_DW-1:0] QSFE_ONES = 16'hffff;
	// Move counter width
	localparam int unsigned QSFE_MCW = 8;
	// Transfer states
	typedef enum logic [2:0] {QSFE_IDLE, QSFE_SHIFT, QSFE_TRAIL, QSFE_MORE_FRAMES_STATE_A} qsfe_state_t;
endpackage

// file: rtl/qsfe_fifo.sv
// Synchronous FIFO with valid/ready on both sides; read data registered.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/1ps
module qsfe_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic flush_i,
	// Write side
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [WIDTH-1:0] wr_data_i,
	// Read side
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [WIDTH-1:0] rd_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	// Storage
	logic [WIDTH-1:0] mem_ff [DEPTH];
	// Pointers with wrap bit
	logic [AW:0] wp_ff;
	logic [AW:0] rp_ff;
	// Registered output word and its valid
	logic [WIDTH-1:0] out_ff;
	logic out_vld_ff;
	wire logic [AW:0] used = wp_ff - rp_ff;
	wire logic full = used == (AW+1)'(DEPTH);
	wire logic mem_empty = used == '0;
	wire logic do_wr = wr_valid_i && !full;
	// Refill output register when it is free or being taken
	wire logic do_rd = !mem_empty && (!out_vld_ff || rd_ready_i);
	assign wr_ready_o = !full;
	assign rd_valid_o = out_vld_ff;
	assign rd_data_o = out_ff;
	// Memory write
	always_ff @(posedge sys_clk_i) begin
		if (do_wr) begin
			mem_ff[wp_ff[AW-1:0]] <= wr_data_i;
		end
	end
	// Pointers and output register
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_ff <= '0;
			rp_ff <= '0;
			out_ff <= '0;
			out_vld_ff <= 1'b0;
		end else if (flush_i) begin
			wp_ff <= '0;
			rp_ff <= '0;
			out_vld_ff <= 1'b0;
		end else begin
			if (do_wr) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (do_rd) begin
				rp_ff <= rp_ff + 1'b1;
				out_ff <= mem_ff[rp_ff[AW-1:0]];
				out_vld_ff <= 1'b1;
			end else if (rd_ready_i) begin
				out_vld_ff <= 1'b0;
			end
		end
	end
endmodule

// file: rtl/qsfe_engine.sv
// Queued serial frame engine, slave and master, with FIFOs and user events.
// Assumes serial pins come from outside; they are synchronised here.
//
// What this block and its software do
// [R1] Flag baud error outside half-to-double rate
// [R2] Software avoids relying on baud error
// [R3] Spike filter guards slave serial inputs
// [R4] Selector 2 picks start-of-frame user event
// [R5] Selector 4 picks receive-buffer-filled user event
// [R6] Move count mode samples user bit at start
// [R7] Software toggles enable to gate buffer events
// [R8] First selector 101 picks master end-of-frame
// [R9] Second selector 101 picks deselect, with interrupt
// [R10] Move count: trail after last, more_frames_state_a waits
// [R11] Software loads next transaction after finish
// [R12] Slave underflow sends all-ones data
// [R13] Software picks parity matching data length
// [R14] Software changes control word between frames
// [R15] Slave deselect soft_reset_select receive bit counter
// [R16] Soft reset 01 clears counter and machine
// [R17] Handler copies data before soft reset
`timescale 1ns/1ps
module qsfe_engine
	import qsfe_pkg::*;
#(
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Configuration
	input wire logic master_mode_i,
	input wire logic [QSFE_TQW-1:0] baud_time_quantum_i,
	input wire logic auto_reset_on_error_en_i,
	input wire logic user_event_irq_en_i,
	input wire logic [2:0] phase_transition_sel_first_i,
	input wire logic [2:0] phase_transition_sel_second_i,
	input wire logic phase_transition_second_irq_en_i,
	input wire logic [1:0] soft_reset_select_i,
	input wire logic soft_reset_stb_i,
	input wire logic move_count_mode_en_i,
	input wire logic [QSFE_MCW-1:0] move_count_config_i,
	// Frame control word
	input wire logic [QSFE_LW-1:0] frame_len_m1_i,
	input wire logic ctrl_word_user_irq_i,
	// Transmit stream in
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic [QSFE_DW-1:0] tx_data_i,
	// Receive stream out
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output logic [QSFE_DW-1:0] rx_data_o,
	// Serial pins
	input wire logic sclk_i,
	input wire logic slave_select_in_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic sclk_o,
	output logic mosi_o,
	output logic ss_n_o,
	// Status
	output logic user_event_flag_o,
	output logic user_irq_o,
	output logic phase_second_irq_o,
	output logic baud_error_o,
	output logic [QSFE_MCW-1:0] move_count_current_o,
	output logic [2:0] state_o
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and spike filter
	logic [2:0] s1_ff;
	logic [2:0] s2_ff;
	// Filtered sclk, ss_n, mosi
	logic [2:0] flt_ff;
	logic [1:0] stab_ff;
	logic [2:0] cand_ff;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_ff <= 3'h2;
			s2_ff <= 3'h2;
		end else begin
			s1_ff <= {mosi_i, slave_select_in_n_i, sclk_i};
			s2_ff <= s1_ff;
		end
	end
	// Level must hold several cycles before accepted, short glitches ignored
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cand_ff <= 3'h2;
			stab_ff <= 2'h0;
			flt_ff <= 3'h2;
		end else if (s2_ff != cand_ff) begin
			cand_ff <= s2_ff;
			stab_ff <= 2'h0;
		end else if (stab_ff < QSFE_SPIKE_CYC) begin
			stab_ff <= stab_ff + 2'h1;
		end else begin
			flt_ff <= cand_ff; // see [R3]
		end
	end
	logic [2:0] fd_ff;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fd_ff <= 3'h2;
		end else begin
			fd_ff <= flt_ff;
		end
	end
	wire logic s_rise = flt_ff[0] && !fd_ff[0];
	wire logic s_fall = !flt_ff[0] && fd_ff[0];
	wire logic ss_sel = !flt_ff[1];
	wire logic ss_desel = flt_ff[1] && !fd_ff[1];
	wire logic ss_start = !flt_ff[1] && fd_ff[1];
	// Master receive line shares the filtered mosi pin input here
	wire logic mosi_i_s = flt_ff[2];
	////////////////////////////////////////////////////////////////////////
	// FIFOs
	logic tx_pop;
	logic tx_avail;
	logic [QSFE_DW-1:0] tx_word;
	logic rx_push;
	logic rx_room;
	logic [QSFE_DW-1:0] rx_word_ff;
	wire logic soft_rst = soft_reset_stb_i && soft_reset_select_i == QSFE_RST_BITSM;
	qsfe_fifo #(.WIDTH(QSFE_DW), .DEPTH(DEPTH)) u_tx (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .flush_i(1'b0),
		.wr_valid_i(tx_valid_i), .wr_ready_o(tx_ready_o), .wr_data_i(tx_data_i),
		.rd_valid_o(tx_avail), .rd_ready_i(tx_pop), .rd_data_o(tx_word)
	);
	qsfe_fifo #(.WIDTH(QSFE_DW), .DEPTH(DEPTH)) u_rx (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .flush_i(1'b0),
		.wr_valid_i(rx_push), .wr_ready_o(rx_room), .wr_data_i(rx_word_ff),
		.rd_valid_o(rx_valid_o), .rd_ready_i(rx_ready_i), .rd_data_o(rx_data_o)
	);
	////////////////////////////////////////////////////////////////////////
	// Transfer state machine
	qsfe_state_t st_ff;
	logic [QSFE_LW-1:0] bit_ff;
	logic [QSFE_DW-1:0] sh_tx_ff;
	logic [QSFE_DW-1:0] sh_rx_ff;
	logic [QSFE_TQW-1:0] tq_ff;
	logic sclk_ff;
	logic ss_n_ff;
	logic usr_bit_ff;
	logic [QSFE_MCW-1:0] mc_ff;
	logic push_ff;
	logic sof_ff;
	logic eof_ff;
	// Shift edges: master uses its own divider, slave the filtered pin
	wire logic tq_hit = tq_ff == baud_time_quantum_i;
	wire logic m_lead = master_mode_i && tq_hit && !sclk_ff;
	wire logic m_trail = master_mode_i && tq_hit && sclk_ff;
	wire logic samp = master_mode_i ? m_lead : s_rise;
	wire logic drive = master_mode_i ? m_trail : s_fall;
	wire logic last_bit = bit_ff == frame_len_m1_i;
	wire logic frame_done = st_ff == QSFE_SHIFT && samp && last_bit;
	wire logic m_start = master_mode_i && tx_avail && (st_ff == QSFE_IDLE || st_ff == QSFE_MORE_FRAMES_STATE_A);
	wire logic s_start = !master_mode_i && st_ff == QSFE_IDLE && ss_start;
	wire logic start = m_start || s_start;
	// Underflow in slave: no word queued, ones go out
	wire logic [QSFE_DW-1:0] load_word = tx_avail ? tx_word : QSFE_ONES; // see [R12]
	wire logic mc_last = mc_ff == '0;
	wire logic baud_err;
	assign tx_pop = start && tx_avail;
	assign rx_push = push_ff;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff <= QSFE_IDLE;
			bit_ff <= QSFE_BIT_ZERO;
			sh_tx_ff <= '0;
			sh_rx_ff <= '0;
			tq_ff <= '0;
			sclk_ff <= 1'b0;
			ss_n_ff <= 1'b1;
			usr_bit_ff <= 1'b0;
			mc_ff <= '0;
			push_ff <= 1'b0;
			rx_word_ff <= '0;
			sof_ff <= 1'b0;
			eof_ff <= 1'b0;
		end else begin
			push_ff <= 1'b0;
			sof_ff <= start;
			eof_ff <= frame_done && master_mode_i;
			tq_ff <= (tq_hit || st_ff != QSFE_SHIFT) ? '0 : tq_ff + 1'b1;
			if (soft_rst || (!master_mode_i && ss_desel) ||
			    (baud_err && auto_reset_on_error_en_i)) begin
				st_ff <= QSFE_IDLE; // see [R15] [R16]
				bit_ff <= QSFE_BIT_ZERO;
				sclk_ff <= 1'b0;
				ss_n_ff <= 1'b1;
			end else begin
				case (st_ff)
				QSFE_IDLE, QSFE_MORE_FRAMES_STATE_A: begin
					if (start) begin
						st_ff <= QSFE_SHIFT;
						bit_ff <= QSFE_BIT_ZERO;
						sh_tx_ff <= load_word;
						ss_n_ff <= !master_mode_i;
						// User bit latched at each frame start; in move count mode only at the first
						if (!move_count_mode_en_i || st_ff == QSFE_IDLE) begin
							usr_bit_ff <= ctrl_word_user_irq_i; // see [R6]
						end
						if (move_count_mode_en_i && st_ff == QSFE_IDLE) begin
							mc_ff <= move_count_config_i;
						end
					end
				end
				QSFE_SHIFT: begin
					if (master_mode_i && tq_hit) begin
						sclk_ff <= !sclk_ff;
					end
					if (samp) begin
						sh_rx_ff <= {sh_rx_ff[QSFE_DW-2:0], master_mode_i ? mosi_i_s : flt_ff[2]};
						bit_ff <= bit_ff + 1'b1;
					end
					if (drive && bit_ff != QSFE_BIT_ZERO) begin
						sh_tx_ff <= {sh_tx_ff[QSFE_DW-2:0], 1'b1};
					end
					if (frame_done) begin
						rx_word_ff <= {sh_rx_ff[QSFE_DW-2:0], master_mode_i ? mosi_i_s : flt_ff[2]};
						push_ff <= rx_room;
						bit_ff <= QSFE_BIT_ZERO;
						// Move count: decrement, trail after last frame
						if (move_count_mode_en_i) begin
							st_ff <= mc_last ? QSFE_TRAIL : QSFE_MORE_FRAMES_STATE_A; // see [R10]
							mc_ff <= mc_last ? mc_ff : mc_ff - 1'b1;
						end else begin
							st_ff <= QSFE_TRAIL;
						end
					end
				end
				QSFE_TRAIL: begin
					sclk_ff <= 1'b0;
					ss_n_ff <= 1'b1;
					st_ff <= QSFE_IDLE;
				end
				default: begin
					st_ff <= QSFE_IDLE;
				end
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Slave baud check: period of sclk against expected (2*(tq+1) cycles)
	logic [QSFE_PW-1:0] per_ff;
	logic berr_ff;
	wire logic [QSFE_PW-1:0] exp_per = QSFE_PW'({baud_time_quantum_i, 1'b0}) + QSFE_PW'(2);
	wire logic per_low = per_ff < {1'b0, exp_per[QSFE_PW-1:1]};
	wire logic per_high = per_ff > {exp_per[QSFE_PW-2:0], 1'b0};
	assign baud_err = !master_mode_i && ss_sel && fd_ff[0] == 1'b0 && s_rise && per_ff != '0 &&
		(per_low || per_high);
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			per_ff <= '0;
			berr_ff <= 1'b0;
		end else begin
			if (s_rise || !ss_sel) begin
				per_ff <= '0;
			end else if (per_ff != '1) begin
				per_ff <= per_ff + 1'b1;
			end
			// Sticky until soft reset; set wins
			if (baud_err) begin
				berr_ff <= 1'b1; // see [R1]
			end else if (soft_rst) begin
				berr_ff <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// User events and phase transition interrupts
	logic user_flag_ff;
	logic uirq_ff;
	logic p2irq_ff;
	wire logic ev_sof = sof_ff && phase_transition_sel_first_i == QSFE_PT_SOF; // see [R4]
	wire logic ev_rbf = push_ff && phase_transition_sel_first_i == QSFE_PT_RBF; // see [R5]
	wire logic ev_eof = eof_ff && phase_transition_sel_first_i == QSFE_PT_EOF; // see [R8]
	wire logic ev_usr = (ev_sof || ev_rbf || ev_eof) && usr_bit_ff && user_event_irq_en_i;
	wire logic ev_p2 = !master_mode_i && ss_desel &&
		phase_transition_sel_second_i == QSFE_PT_SSDESEL; // see [R9]
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			user_flag_ff <= 1'b0;
			uirq_ff <= 1'b0;
			p2irq_ff <= 1'b0;
		end else begin
			if (ev_usr) begin
				user_flag_ff <= 1'b1;
			end else if (soft_rst) begin
				user_flag_ff <= 1'b0;
			end
			uirq_ff <= ev_usr;
			p2irq_ff <= ev_p2 && phase_transition_second_irq_en_i; // see [R9]
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Registered pin and status outputs
	logic miso_ff;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			miso_ff <= 1'b1;
		end else begin
			miso_ff <= sh_tx_ff[QSFE_DW-1];
		end
	end
	assign miso_o = miso_ff;
	assign mosi_o = miso_ff;
	assign sclk_o = sclk_ff;
	assign ss_n_o = ss_n_ff;
	assign user_event_flag_o = user_flag_ff;
	assign user_irq_o = uirq_ff;
	assign phase_second_irq_o = p2irq_ff;
	assign baud_error_o = berr_ff;
	assign move_count_current_o = mc_ff;
	assign state_o = st_ff;
endmodule

// file: sim/qsfe_spi_master_model.sv
// Remote serial master that clocks frames into the engine in slave mode.
// Assumes the bench calls xfer with the system clock running.
`timescale 1ns/1ps
module qsfe_spi_master_model (
	// Serial pins toward the engine
	output logic sclk_o,
	output logic ss_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	// Idle: clock parked low, select released
	initial begin
		sclk_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// One frame, MSB first; miso read late because the slave pin path is slow
	task automatic xfer(input logic [15:0] d, input int n, input int h, input bit g, output logic [15:0] got);
		got = 16'h0000;
		ss_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi_o = d[i];
			#(h);
			sclk_o = 1'b1;
			#(h);
			got = {got[14:0], miso_i};
			sclk_o = 1'b0;
			// Short spike within the low phase
			if (g && i == 4) begin
				#(h / 4);
				sclk_o = 1'b1;
				#30;
				sclk_o = 1'b0;
			end
		end
		#(h);
		ss_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released line shows no stale bit
	endtask
endmodule

// file: sim/qsfe_engine_asserts.sv
// Checker on the engine's ports: events, flags, soft reset, deselect.
// Assumes one clock domain and slave operation by the bench.
`timescale 1ns/1ps
module qsfe_engine_asserts (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Controls
	input wire logic master_mode_i,
	input wire logic user_event_irq_en_i,
	input wire logic phase_transition_second_irq_en_i,
	input wire logic [1:0] soft_reset_select_i,
	input wire logic soft_reset_stb_i,
	input wire logic slave_select_in_n_i,
	// Status
	input wire logic user_event_flag_o,
	input wire logic user_irq_o,
	input wire logic phase_second_irq_o,
	input wire logic baud_error_o,
	input wire logic [2:0] state_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Soft reset qualified by code; link idle so no set can win
	wire logic soft_clr = soft_reset_stb_i && soft_reset_select_i == 2'h1 && slave_select_in_n_i;
	////////////////////////////////////////////////////////////////////////
	a_soft_state: assert property (soft_clr |-> ##[1:2] state_o == 3'h0) else $error("state not idle");
	a_soft_flags: assert property (soft_clr |-> ##2 !baud_error_o && !user_event_flag_o) else $error("flags kept");
	a_baud_hold: assert property (baud_error_o && !soft_reset_stb_i |=> baud_error_o) else $error("baud lost");
	a_irq_pulse: assert property (user_irq_o |=> !user_irq_o) else $error("user irq long");
	a_irq_flag: assert property (user_irq_o |-> ##[0:1] user_event_flag_o) else $error("irq no flag");
	a_irq_gate: assert property (!user_event_irq_en_i [*3] |-> !user_irq_o) else $error("irq gated off");
	a_p2_gate: assert property (!phase_transition_second_irq_en_i [*3] |-> !phase_second_irq_o) else $error("p2 off");
	a_p2_pulse: assert property (phase_second_irq_o |=> !phase_second_irq_o) else $error("p2 irq long");
	a_p2_cause: assert property (phase_second_irq_o |-> $past(slave_select_in_n_i, 3)) else $error("p2 no deselect");
	a_desel_idle: assert property ($rose(slave_select_in_n_i) && !master_mode_i |-> ##[1:16] state_o == 3'h0)
		else $error("deselect not idle");
	c_user: cover property (user_irq_o);
	c_p2: cover property (phase_second_irq_o);
	c_baud: cover property ($rose(baud_error_o));
endmodule
bind qsfe_engine qsfe_engine_asserts u_qsfe_engine_asserts (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
	.master_mode_i(master_mode_i), .user_event_irq_en_i(user_event_irq_en_i),
	.phase_transition_second_irq_en_i(phase_transition_second_irq_en_i), .soft_reset_select_i(soft_reset_select_i),
	.soft_reset_stb_i(soft_reset_stb_i), .slave_select_in_n_i(slave_select_in_n_i),
	.user_event_flag_o(user_event_flag_o), .user_irq_o(user_irq_o), .phase_second_irq_o(phase_second_irq_o),
	.baud_error_o(baud_error_o), .state_o(state_o));

// file: sim/qsfe_engine_tb.sv
// Bench for the engine in slave mode against a remote master model.
// Assumes a 50 ns clock and a 400 ns nominal link period.
`timescale 1ns/1ps
module qsfe_engine_tb;
	import qsfe_pkg::*;
	logic sys_clk_i = 1'b0, arst_n_i = 1'b0, ev_en = 1'b1, p2_en = 1'b1, uirq = 1'b1, sstb = 1'b0;
	logic [2:0] sel1 = QSFE_PT_RBF;
	logic [1:0] ssel = 2'h0;
	logic [4:0] flen = 5'h0f;
	logic tx_valid_i = 1'b0, rx_ready_i = 1'b0, tx_ready_o, rx_valid_o, flag, p2irq;
	logic [15:0] tx_data_i = 16'h0000, rx_data_o;
	wire l_sclk, l_ss_n, l_mosi, l_miso;
	// Master-side pins and move count; all but mosi, which mirrors miso, idle in slave mode
	logic m_sclk, m_ss_n, m_mosi;
	logic [7:0] mc_cur;
	int n_errors = 0, checked = 0, p2_cnt = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	// Deselect pulses counted for the event checks
	always @(posedge sys_clk_i) if (p2irq === 1'b1) p2_cnt++;
	qsfe_spi_master_model u_qsfe_spi_master_model (.sclk_o(l_sclk), .ss_n_o(l_ss_n), .mosi_o(l_mosi), .miso_i(l_miso));
	// Quantum 3 gives the nominal 400 ns period
	qsfe_engine u_qsfe_engine (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .master_mode_i(1'b0),
		.baud_time_quantum_i(8'h03), .auto_reset_on_error_en_i(1'b0), .user_event_irq_en_i(ev_en),
		.phase_transition_sel_first_i(sel1), .phase_transition_sel_second_i(QSFE_PT_SSDESEL),
		.phase_transition_second_irq_en_i(p2_en), .soft_reset_select_i(ssel), .soft_reset_stb_i(sstb),
		.move_count_mode_en_i(1'b0), .move_count_config_i(8'h00), .frame_len_m1_i(flen),
		.ctrl_word_user_irq_i(uirq), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i),
		.rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .sclk_i(l_sclk),
		.slave_select_in_n_i(l_ss_n), .mosi_i(l_mosi), .miso_o(l_miso), .sclk_o(m_sclk), .mosi_o(m_mosi),
		.ss_n_o(m_ss_n), .user_event_flag_o(flag), .user_irq_o(), .phase_second_irq_o(p2irq),
		.baud_error_o(), .move_count_current_o(mc_cur), .state_o());
	// No parity bit in this engine's frames
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic push(input logic [15:0] d);
		tx_data_i = d;
		tx_valid_i = 1'b1;
		do @(posedge sys_clk_i); while (tx_ready_o !== 1'b1);
		@(negedge sys_clk_i);
		tx_valid_i = 1'b0;
	endtask
	// Frame of n bits at half period h; g adds a spike
	task automatic frame(input logic [15:0] d, input int n, input int h, input bit g, input logic [15:0] exp);
		logic [15:0] got;
		@(negedge sys_clk_i);
		u_qsfe_spi_master_model.xfer(d, n, h, g, got);
		chk("miso word", exp, got);
		repeat (40) @(negedge sys_clk_i);
	endtask
	task automatic pop(input logic [15:0] exp);
		int k;
		k = 0;
		while (rx_valid_o !== 1'b1 && k < 50) begin
			@(negedge sys_clk_i);
			k++;
		end
		chk("rx word", exp, rx_data_o);
		rx_ready_i = 1'b1;
		@(negedge sys_clk_i);
		rx_ready_i = 1'b0;
	endtask
	task automatic sreset();
		ssel = QSFE_RST_BITSM;
		sstb = 1'b1;
		@(negedge sys_clk_i);
		sstb = 1'b0;
		repeat (4) @(negedge sys_clk_i);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog well beyond the planned seven frames
	initial begin
		#400000;
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (4) @(negedge sys_clk_i);
		arst_n_i = 1'b1;
		push(16'ha5c3);
		frame(16'h3c5a, 16, 200, 1'b1, 16'ha5c3);
		pop(16'h3c5a);
		chk("rbf flag", 16'h0001, {15'h0, flag});
		chk("deselect irqs", 16'h0001, p2_cnt[15:0]);
		chk("baud error", 16'h0000, {15'h0, u_qsfe_engine.baud_error_o});
		chk("slave ss_n out", 16'h0001, {15'h0, m_ss_n});
		chk("slave sclk out", 16'h0000, {15'h0, m_sclk});
		chk("move count", 16'h0000, {8'h00, mc_cur});
		frame(16'h0ff0, 16, 200, 1'b0, 16'hffff);
		pop(16'h0ff0);
		// Short frame is dropped; deselect must realign the next one
		frame(16'h00a5, 8, 200, 1'b0, 16'h00ff);
		chk("rx after short", 16'h0000, {15'h0, rx_valid_o});
		frame(16'h1234, 16, 200, 1'b0, 16'hffff);
		pop(16'h1234);
		sreset();
		chk("flag cleared", 16'h0000, {15'h0, flag});
		ev_en = 1'b0;
		frame(16'h5555, 16, 200, 1'b0, 16'hffff);
		pop(16'h5555);
		chk("gated flag", 16'h0000, {15'h0, flag});
		ev_en = 1'b1;
		sel1 = QSFE_PT_SOF;
		frame(16'hc001, 16, 200, 1'b0, 16'hffff);
		pop(16'hc001);
		chk("sof flag", 16'h0001, {15'h0, flag});
		sreset();
		frame(16'h8181, 16, 800, 1'b0, 16'hffff);
		pop(16'h8181);
		chk("slow baud", 16'h0001, {15'h0, u_qsfe_engine.baud_error_o});
		chk("mosi out ones", 16'h0001, {15'h0, m_mosi});
		sreset();
		chk("baud cleared", 16'h0000, {15'h0, u_qsfe_engine.baud_error_o});
		chk("deselect total", 16'h0007, p2_cnt[15:0]);
		print_verdict();
	end
endmodule
